// ===== rtl/elc_consts.svh
// Offsets, field positions, reset values and codes of the per-link E1 line configuration registers
`ifndef ELC_CONSTS_SVH
`define ELC_CONSTS_SVH

// Register indices; byte address is four times the index, link in index bits 9:8
`define ELC_IDX_TX_SHAPE      8'h23
`define ELC_IDX_TX_TRIM       8'h24
`define ELC_IDX_TX_ACCESS     8'h25
`define ELC_IDX_TX_WVALUE     8'h26
`define ELC_IDX_RX_DEJITTER   8'h27
`define ELC_IDX_RX_PATH       8'h28
`define ELC_IDX_RX_EQ_LOSS    8'h29
`define ELC_IDX_RX_SPREAD     8'h39
`define ELC_IDX_TX_RVALUE     8'h3a

// Field positions
`define ELC_ACC_DONE_BIT      7
`define ELC_ACC_DIR_BIT       6
`define ELC_DJ_PEAK_BIT       5
`define ELC_DJ_WIDEN_BIT      4
`define ELC_DJ_EN_BIT         3
`define ELC_DJ_CORNER_BIT     0
`define ELC_RX_OFF_BIT        4
`define ELC_RX_CODE_BIT       1
`define ELC_RX_EQUALIZER_ENABLE_BIT         6

// Reset values
`define ELC_SHAPE_RESET       4'h0
`define ELC_TRIM_RESET        6'h21
`define ELC_EQ_LOSS_RESET     7'h15

// Jitter FIFO depths and near-limit margins in bits
`define ELC_DEPTH_128         8'h80
`define ELC_DEPTH_64          8'h40
`define ELC_DEPTH_32          8'h20
`define ELC_MARGIN_128        8'h04
`define ELC_MARGIN_64         8'h03
`define ELC_MARGIN_32         8'h02

`endif

// ===== rtl/elc_link_regs.sv
// Four-link E1 line configuration register bank with pulse template RAM, APB slave
//
// Decided for this implementation: the APB interface to the registers.
`include "elc_consts.svh"
`default_nettype none
module elc_link_regs (
  input  wire logic             pclk,               // APB clock, 100 MHz
  input  wire logic             presetn,            // Asynchronous reset, active low
  input  wire logic             psel,               // APB select
  input  wire logic             penable,            // APB access phase
  input  wire logic             pwrite,             // APB direction, 1 = write
  input  wire logic [11:0]      paddr,              // APB byte address
  input  wire logic [31:0]      pwdata,             // APB write data
  input  wire logic [3:0]       pstrb,              // APB byte strobes
  output logic      [31:0]      prdata,             // APB read data
  output logic                  pready,             // APB ready, no wait states
  output logic                  pslverr,            // APB error on unmapped address
  input  wire logic [3:0][6:0]  rx_fifo_spread,     // Current pointer distance per link
  input  wire logic [3:0][5:0]  tx_wave_addr,       // Template playback address per link
  output logic      [3:0][6:0]  tx_wave_sample,     // Template playback sample per link
  output logic      [3:0][1:0]  tx_shape_class,     // Decoded pulse shape per link
  output logic      [3:0][5:0]  tx_dac_scale,       // Amplitude step applied to D/A
  output logic      [3:0]       rx_dejitter_enable, // Attenuator inserted in receive path
  output logic      [3:0][7:0]  rx_dejitter_bits,   // Attenuator FIFO depth in bits
  output logic      [3:0]       rx_dejitter_corner_select, // 0 = 6.77 Hz, 1 = 0.87 Hz
  output logic      [3:0]       rx_dejitter_track_wide,    // Attenuation suspended near limit
  output logic      [3:0]       rx_power_down,      // Receive path powered down
  output logic      [3:0]       rx_line_code_select,       // 0 = HDB3, 1 = AMI
  output logic      [3:0]       rx_equalizer_enable,       // Long haul equalizer on
  output logic      [3:0][4:0]  rx_signal_loss_threshold   // Loss declare threshold code
);

  default clocking elc_cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // ==========================================================
  // APB decode
  // ==========================================================
  logic [9:0] acc_idx;
  logic [1:0] acc_link;
  logic [7:0] acc_low;
  logic       acc_mapped;
  logic       wr_en;
  logic [7:0] rd_mux;

  assign acc_idx  = paddr[11:2];
  assign acc_link = acc_idx[9:8];
  assign acc_low  = acc_idx[7:0];
  // Every register answers at once, so the access phase never stretches
  assign pready   = 1'b1;

  always_comb begin
    acc_mapped = 1'b0;
    if (paddr[1:0] == 2'h0) begin
      unique case (acc_low)
        `ELC_IDX_TX_SHAPE, `ELC_IDX_TX_TRIM, `ELC_IDX_TX_ACCESS, `ELC_IDX_TX_WVALUE,
        `ELC_IDX_RX_DEJITTER, `ELC_IDX_RX_PATH, `ELC_IDX_RX_EQ_LOSS,
        `ELC_IDX_RX_SPREAD, `ELC_IDX_TX_RVALUE: acc_mapped = 1'b1;
        default: acc_mapped = 1'b0;
      endcase
    end
  end

  // Each register is one byte in the low lane of an aligned word;
  // the upper lanes hold nothing, so their strobes are not looked at
  // Only the low byte lane carries data; writes without it are ignored
  assign wr_en = psel & penable & pwrite & pstrb[0] & acc_mapped;

  // ==========================================================
  // Per-link register storage
  // ==========================================================
  logic [3:0] shape_r    [0:3];
  logic [5:0] trim_r     [0:3];
  logic [7:0] access_r   [0:3];
  logic       done_prev_r[0:3];
  logic [6:0] wvalue_r   [0:3];
  logic [5:0] dejit_r    [0:3];
  logic [4:0] rxpath_r   [0:3];
  logic [6:0] eqloss_r   [0:3];
  logic [6:0] spread_r   [0:3];
  logic [6:0] rvalue_r   [0:3];
  logic [6:0] tmpl_ram   [0:3][0:63];
  logic [3:0] is_arb;
  logic [3:0] tmpl_fire;
  logic [3:0] tmpl_wr;
  logic [3:0] tmpl_rd;
  logic [5:0] tmpl_addr  [0:3];

  genvar l;
  generate
    for (l = 0; l < 4; l++) begin : g_link
      logic [7:0] depth_bits;
      logic [7:0] margin;
      logic [7:0] spread_w;
      logic [1:0] shape_cls;
      logic       wide_w;

      // ==========================================================
      // Software writable fields
      // ==========================================================
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          shape_r[l]  <= `ELC_SHAPE_RESET;
          trim_r[l]   <= `ELC_TRIM_RESET;
          access_r[l] <= 8'h00;
          wvalue_r[l] <= 7'h00;
          dejit_r[l]  <= 6'h00;
          rxpath_r[l] <= 5'h00;
          eqloss_r[l] <= `ELC_EQ_LOSS_RESET;
        end else if (wr_en && acc_link == 2'(l)) begin
          unique case (acc_low)
            `ELC_IDX_TX_SHAPE:    shape_r[l]  <= pwdata[3:0];
            `ELC_IDX_TX_TRIM:     trim_r[l]   <= pwdata[5:0];
            `ELC_IDX_TX_ACCESS:   access_r[l] <= pwdata[7:0];
            `ELC_IDX_TX_WVALUE:   wvalue_r[l] <= pwdata[6:0];
            `ELC_IDX_RX_DEJITTER: dejit_r[l]  <= pwdata[5:0];
            `ELC_IDX_RX_PATH:     rxpath_r[l] <= {pwdata[4], 2'h0, pwdata[1], 1'b0};
            `ELC_IDX_RX_EQ_LOSS:  eqloss_r[l] <= {pwdata[6], 1'b0, pwdata[4:0]};
            default: ;
          endcase
        end
      end

      // ==========================================================
      // Pulse template RAM access
      // ==========================================================
      assign is_arb[l]    = (shape_r[l][3:2] == 2'h3);
      assign tmpl_addr[l] = access_r[l][5:0];
      // Acting on the enable edge makes one access per set, however long software leaves it
      assign tmpl_fire[l] = access_r[l][`ELC_ACC_DONE_BIT] & ~done_prev_r[l] & is_arb[l];
      assign tmpl_wr[l]   = tmpl_fire[l] & ~access_r[l][`ELC_ACC_DIR_BIT];
      assign tmpl_rd[l]   = tmpl_fire[l] & access_r[l][`ELC_ACC_DIR_BIT];

      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          done_prev_r[l] <= 1'b0;
          rvalue_r[l]    <= 7'h00;
        end else begin
          done_prev_r[l] <= access_r[l][`ELC_ACC_DONE_BIT];
          if (tmpl_rd[l]) begin
            rvalue_r[l] <= tmpl_ram[l][tmpl_addr[l]];
          end
        end
      end

      // Playback reads the same array; a write and a playback read of one
      // word in one cycle return the old sample
      // Template storage has no reset; software loads it after selecting 11xx, as writes only reach it then
      always_ff @(posedge pclk) begin
        if (tmpl_wr[l]) begin
          tmpl_ram[l][tmpl_addr[l]] <= wvalue_r[l];
        end
        tx_wave_sample[l] <= tmpl_ram[l][tx_wave_addr[l]];
      end

      // ==========================================================
      // Jitter FIFO spread readout
      // ==========================================================
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          spread_r[l] <= 7'h00;
        end else if (!dejit_r[l][`ELC_DJ_PEAK_BIT]) begin
          spread_r[l] <= rx_fifo_spread[l];
        end else if (rx_fifo_spread[l] > spread_r[l]) begin
          spread_r[l] <= rx_fifo_spread[l];
        end
      end

      // ==========================================================
      // Decoded controls
      // ==========================================================
      always_comb begin
        unique case (dejit_r[l][2:1])
          2'h0: begin
            depth_bits = `ELC_DEPTH_128;
            margin     = `ELC_MARGIN_128;
          end
          2'h1: begin
            depth_bits = `ELC_DEPTH_64;
            margin     = `ELC_MARGIN_64;
          end
          default: begin
            depth_bits = `ELC_DEPTH_32;
            margin     = `ELC_MARGIN_32;
          end
        endcase
      end

      assign spread_w = {1'b0, rx_fifo_spread[l]};
      // Near either end of the FIFO the attenuator tracks instead of filtering
      assign wide_w = dejit_r[l][`ELC_DJ_EN_BIT] & dejit_r[l][`ELC_DJ_WIDEN_BIT]
                    & ((spread_w <= margin) | (spread_w >= depth_bits - margin));

      always_comb begin
        unique case (shape_r[l])
          4'h0:                   shape_cls = elc_pkg::ELC_SHAPE_75;
          4'h1:                   shape_cls = elc_pkg::ELC_SHAPE_120;
          4'hc, 4'hd, 4'he, 4'hf: shape_cls = elc_pkg::ELC_SHAPE_ARB;
          default:                shape_cls = elc_pkg::ELC_SHAPE_RSVD;
        endcase
      end

      // ==========================================================
      // Registered control outputs
      // ==========================================================
      // One clock of latency keeps decode glitches away from the line side
      // when software rewrites a field; nothing there needs a faster answer
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          tx_shape_class[l]            <= elc_pkg::ELC_SHAPE_75;
          tx_dac_scale[l]              <= `ELC_TRIM_RESET;
          rx_dejitter_enable[l]        <= 1'b0;
          rx_dejitter_bits[l]          <= `ELC_DEPTH_128;
          rx_dejitter_corner_select[l] <= 1'b0;
          rx_dejitter_track_wide[l]    <= 1'b0;
          rx_power_down[l]             <= 1'b0;
          rx_line_code_select[l]       <= 1'b0;
          rx_equalizer_enable[l]       <= 1'b0;
          rx_signal_loss_threshold[l]  <= 5'(`ELC_EQ_LOSS_RESET);
        end else begin
          tx_shape_class[l]            <= shape_cls;
          tx_dac_scale[l]              <= is_arb[l] ? trim_r[l] : `ELC_TRIM_RESET;
          rx_dejitter_enable[l]        <= dejit_r[l][`ELC_DJ_EN_BIT];
          rx_dejitter_bits[l]          <= depth_bits;
          rx_dejitter_corner_select[l] <= dejit_r[l][`ELC_DJ_CORNER_BIT];
          rx_dejitter_track_wide[l]    <= wide_w;
          rx_power_down[l]             <= rxpath_r[l][`ELC_RX_OFF_BIT];
          rx_line_code_select[l]       <= rxpath_r[l][`ELC_RX_CODE_BIT];
          rx_equalizer_enable[l]       <= eqloss_r[l][`ELC_RX_EQUALIZER_ENABLE_BIT];
          rx_signal_loss_threshold[l]  <= eqloss_r[l][4:0];
        end
      end

      // ==========================================================
      // Checks
      // ==========================================================
      // Transmit shape and amplitude
      trim_gate_a: assert property (!is_arb[l] |=> tx_dac_scale[l] == 6'h21)
        else $error("trim applied outside arbitrary waveform");

      trim_pass_a: assert property (is_arb[l] |=> tx_dac_scale[l] == $past(trim_r[l]))
        else $error("trim not applied to arbitrary waveform");

      shape_75_a: assert property (shape_r[l] == 4'h0 |=> tx_shape_class[l] == 2'h0)
        else $error("code 0000 not decoded as 75 ohm");

      shape_120_a: assert property (shape_r[l] == 4'h1 |=> tx_shape_class[l] == 2'h1)
        else $error("code 0001 not decoded as 120 ohm");

      shape_arb_a: assert property (shape_r[l][3:2] == 2'h3 |=> tx_shape_class[l] == 2'h3)
        else $error("code 11xx not decoded as arbitrary");

      shape_rsvd_a: assert property (shape_r[l] inside {[4'h2:4'hb]} |=> tx_shape_class[l] == 2'h2)
        else $error("reserved code not decoded as reserved");

      // Template RAM
      tmpl_store_a: assert property (tmpl_wr[l] |=> tmpl_ram[l][$past(tmpl_addr[l])] == $past(wvalue_r[l]))
        else $error("template write did not store value");

      no_access_a: assert property (!is_arb[l] |=> !$past(tmpl_wr[l]) && !$past(tmpl_rd[l]))
        else $error("template access without arbitrary shape");

      single_write_a: assert property (tmpl_wr[l] |=> !tmpl_wr[l])
        else $error("template write repeated while enable held");

      access_off_a: assert property (!access_r[l][7] |-> !tmpl_fire[l])
        else $error("template access with enable clear");

      read_data_a: assert property (tmpl_rd[l] |=> rvalue_r[l] == $past(tmpl_ram[l][tmpl_addr[l]]))
        else $error("template read value wrong");

      read_once_a: assert property (tmpl_rd[l] |=> !tmpl_rd[l])
        else $error("template read repeated while enable held");

      // Jitter attenuator
      follow_mode_a: assert property (!dejit_r[l][5] ##1 !dejit_r[l][5] |-> spread_r[l] == $past(rx_fifo_spread[l]))
        else $error("readout does not follow spread");

      peak_hold_a: assert property (dejit_r[l][5] && rx_fifo_spread[l] <= spread_r[l] |=> $stable(spread_r[l]))
        else $error("peak readout changed without larger spread");

      peak_grow_a: assert property (dejit_r[l][5] && rx_fifo_spread[l] > spread_r[l] |=> spread_r[l] == $past(rx_fifo_spread[l]))
        else $error("peak readout missed larger spread");

      widen_off_a: assert property (!dejit_r[l][4] |=> !rx_dejitter_track_wide[l])
        else $error("widening without limit widen bit");

      widen_near_a: assert property (dejit_r[l][4:1] == 4'hc && rx_fifo_spread[l] <= 7'd4 |=> rx_dejitter_track_wide[l])
        else $error("no widening near empty limit");

      widen_mid_a: assert property (dejit_r[l][2:1] == 2'h0 && rx_fifo_spread[l] inside {[7'd5:7'd123]}
                                    |=> !rx_dejitter_track_wide[l])
        else $error("widening outside the limit window");

      enable_map_a: assert property (1'b1 |=> rx_dejitter_enable[l] == $past(dejit_r[l][3]))
        else $error("attenuator enable not following bit");

      depth_map_a: assert property (dejit_r[l][2:1] == 2'h1 |=> rx_dejitter_bits[l] == 8'h40)
        else $error("depth 01 is not 64 bits");

      depth_128_a: assert property (dejit_r[l][2:1] == 2'h0 |=> rx_dejitter_bits[l] == 8'h80)
        else $error("depth 00 is not 128 bits");

      depth_32_a: assert property (dejit_r[l][2] |=> rx_dejitter_bits[l] == 8'h20)
        else $error("depth 1x is not 32 bits");

      corner_map_a: assert property (1'b1 |=> rx_dejitter_corner_select[l] == $past(dejit_r[l][0]))
        else $error("corner select not following bit");

      // Receive path and link isolation
      power_map_a: assert property (1'b1 |=> rx_power_down[l] == $past(rxpath_r[l][4]))
        else $error("power down not following bit");

      code_map_a: assert property (1'b1 |=> rx_line_code_select[l] == $past(rxpath_r[l][1]))
        else $error("line code select not following bit");

      eq_map_a: assert property (1'b1 |=> rx_equalizer_enable[l] == $past(eqloss_r[l][6]))
        else $error("equalizer enable not following bit");

      loss_map_a: assert property (1'b1 |=> rx_signal_loss_threshold[l] == $past(eqloss_r[l][4:0]))
        else $error("loss threshold not following field");

      link_keep_a: assert property (wr_en && acc_link != 2'(l) |=> $stable(shape_r[l]) && $stable(dejit_r[l]))
        else $error("write to another link changed this link");

    end
  endgenerate

  // ==========================================================
  // Read data, captured in the setup cycle
  // ==========================================================
  always_comb begin
    unique case (acc_low)
      `ELC_IDX_TX_SHAPE:    rd_mux = {4'h0, shape_r[acc_link]};
      `ELC_IDX_TX_TRIM:     rd_mux = {2'h0, trim_r[acc_link]};
      `ELC_IDX_TX_ACCESS:   rd_mux = access_r[acc_link];
      `ELC_IDX_TX_WVALUE:   rd_mux = {1'b0, wvalue_r[acc_link]};
      `ELC_IDX_RX_DEJITTER: rd_mux = {2'h0, dejit_r[acc_link]};
      `ELC_IDX_RX_PATH:     rd_mux = {3'h0, rxpath_r[acc_link]};
      `ELC_IDX_RX_EQ_LOSS:  rd_mux = {1'b0, eqloss_r[acc_link]};
      `ELC_IDX_RX_SPREAD:   rd_mux = {1'b0, spread_r[acc_link]};
      `ELC_IDX_TX_RVALUE:   rd_mux = {1'b0, rvalue_r[acc_link]};
      default:              rd_mux = 8'h00;
    endcase
  end

  // Read data is taken in the setup cycle so it stands for the whole
  // access phase; the bus then needs no wait states
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (psel && !penable) begin
      prdata  <= acc_mapped ? {24'h00_0000, rd_mux} : 32'h0000_0000;
      pslverr <= ~acc_mapped;
    end
  end

  unmapped_err_a: assert property (psel && !penable && paddr[1:0] != 2'h0 |=> pslverr)
    else $error("misaligned access not flagged");

  ready_const_a: assert property (psel && penable |-> pready)
    else $error("ready low in access phase");

  rd_upper_a: assert property (psel && !penable |=> prdata[31:8] == 24'h00_0000)
    else $error("read data upper bytes not zero");

  err_data_a: assert property (psel && !penable && !acc_mapped |=> pslverr && prdata == 32'h0000_0000)
    else $error("unmapped access not zeroed and flagged");

endmodule // elc_link_regs
`default_nettype wire

// ===== rtl/elc_pkg.sv
// Types shared by the per-link E1 line configuration registers
`default_nettype none
package elc_pkg;
  // Decoded transmit pulse shape; codes follow 75 -> 120 -> reserved -> arbitrary
  typedef enum logic [1:0] {
    ELC_SHAPE_75   = 2'h0,
    ELC_SHAPE_120  = 2'h1,
    ELC_SHAPE_ARB  = 2'h3,
    ELC_SHAPE_RSVD = 2'h2
  } elc_shape_t;
endpackage
`default_nettype wire

// ===== tb/tb_e1_link_line_config_regs.sv
// Self-checking testbench for the four-link E1 line configuration register bank
`include "elc_consts.svh"
`default_nettype none
module tb_e1_link_line_config_regs;
  timeunit 1ns;
  timeprecision 100ps;
  logic            pclk;
  logic            presetn;
  logic            psel;
  logic            penable;
  logic            pwrite;
  logic [11:0]     paddr;
  logic [31:0]     pwdata;
  logic [3:0]      pstrb;
  logic [31:0]     prdata;
  logic            pready;
  logic            pslverr;
  logic [3:0][6:0] rx_fifo_spread;
  logic [3:0][5:0] tx_wave_addr;
  logic [3:0][6:0] tx_wave_sample;
  logic [3:0][1:0] tx_shape_class;
  logic [3:0][5:0] tx_dac_scale;
  logic [3:0]      rx_dejitter_enable;
  logic [3:0][7:0] rx_dejitter_bits;
  logic [3:0]      rx_dejitter_corner_select;
  logic [3:0]      rx_dejitter_track_wide;
  logic [3:0]      rx_power_down;
  logic [3:0]      rx_line_code_select;
  logic [3:0]      rx_equalizer_enable;
  logic [3:0][4:0] rx_signal_loss_threshold;
  int              num_errors;
  int              n_compared;
  logic [7:0]      rd;
  logic            er;

  elc_link_regs elc_link_regs_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rx_fifo_spread(rx_fifo_spread), .tx_wave_addr(tx_wave_addr), .tx_wave_sample(tx_wave_sample),
    .tx_shape_class(tx_shape_class), .tx_dac_scale(tx_dac_scale), .rx_dejitter_enable(rx_dejitter_enable),
    .rx_dejitter_bits(rx_dejitter_bits), .rx_dejitter_corner_select(rx_dejitter_corner_select),
    .rx_dejitter_track_wide(rx_dejitter_track_wide), .rx_power_down(rx_power_down),
    .rx_line_code_select(rx_line_code_select), .rx_equalizer_enable(rx_equalizer_enable),
    .rx_signal_loss_threshold(rx_signal_loss_threshold));

  // ==========================================================
  // Clock, bus tasks and comparison
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
      num_errors++;
    end
  endtask

  // Called just after a rising edge; ends with one idle cycle so psel is never set twice in a step
  task automatic apb(input logic wr, input logic [1:0] ln, input logic [7:0] idx, input logic [7:0] wd);
    int n;
    n = 0;
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= {ln, idx, 2'b00}; pwdata <= {24'h0, wd};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      num_errors++;
      end_sim();
    end
    rd = prdata[7:0];
    er = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic rchk(input string name, input logic [1:0] ln, input logic [7:0] idx, input logic [7:0] exp);
    apb(1'b0, ln, idx, 8'h00);
    chk(name, {24'h0, exp}, {24'h0, rd});
  endtask

  task automatic end_sim;
    if (num_errors == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_reset;
    rchk("shape reset", 2'd0, `ELC_IDX_TX_SHAPE, 8'h00);
    rchk("trim reset", 2'd2, `ELC_IDX_TX_TRIM, 8'h21);
    rchk("eq loss reset", 2'd1, `ELC_IDX_RX_EQ_LOSS, 8'h15);
    chk("dac scale reset", 32'h21, {26'h0, tx_dac_scale[3]});
    chk("loss thr reset", 32'h15, {27'h0, rx_signal_loss_threshold[0]});
    apb(1'b0, 2'd0, 8'h00, 8'h00);
    chk("unmapped err", 32'h1, {31'h0, er});
    apb(1'b1, 2'd0, `ELC_IDX_RX_SPREAD, 8'h55);
    chk("ro write err", 32'h0, {31'h0, er});
  endtask

  task automatic t_shape;
    logic [1:0] cls;
    apb(1'b1, 2'd1, `ELC_IDX_TX_TRIM, 8'h2a);
    for (int c = 0; c < 16; c++) begin
      apb(1'b1, 2'd1, `ELC_IDX_TX_SHAPE, 8'(c));
      @(posedge pclk);
      cls = (c == 0) ? 2'd0 : (c == 1) ? 2'd1 : (c >= 12) ? 2'd3 : 2'd2;
      chk("shape class", {30'h0, cls}, {30'h0, tx_shape_class[1]});
      chk("dac scale", (c >= 12) ? 32'h2a : 32'h21, {26'h0, tx_dac_scale[1]});
    end
  endtask

  task automatic wave_chk(input logic [5:0] a, input logic [6:0] exp);
    tx_wave_addr[2] <= a;
    repeat (2) @(posedge pclk);
    chk("template sample", {25'h0, exp}, {25'h0, tx_wave_sample[2]});
  endtask

  task automatic t_template;
    apb(1'b1, 2'd2, `ELC_IDX_TX_SHAPE, 8'h0c);
    apb(1'b1, 2'd2, `ELC_IDX_TX_WVALUE, 8'h5a);
    apb(1'b1, 2'd2, `ELC_IDX_TX_ACCESS, 8'h3f);
    apb(1'b1, 2'd2, `ELC_IDX_TX_ACCESS, 8'hbf);
    apb(1'b1, 2'd2, `ELC_IDX_TX_WVALUE, 8'h23);
    apb(1'b1, 2'd2, `ELC_IDX_TX_ACCESS, 8'hbf);
    apb(1'b1, 2'd2, `ELC_IDX_TX_ACCESS, 8'h00);
    apb(1'b1, 2'd2, `ELC_IDX_TX_ACCESS, 8'h80);
    wave_chk(6'h3f, 7'h5a);
    wave_chk(6'h00, 7'h23);
    apb(1'b1, 2'd2, `ELC_IDX_TX_ACCESS, 8'h3f);
    apb(1'b1, 2'd2, `ELC_IDX_TX_ACCESS, 8'hff);
    rchk("template read", 2'd2, `ELC_IDX_TX_RVALUE, 8'h5a);
    wave_chk(6'h3f, 7'h5a);
    apb(1'b1, 2'd2, `ELC_IDX_TX_ACCESS, 8'h00);
    apb(1'b1, 2'd2, `ELC_IDX_TX_SHAPE, 8'h01);
    apb(1'b1, 2'd2, `ELC_IDX_TX_WVALUE, 8'h11);
    apb(1'b1, 2'd2, `ELC_IDX_TX_ACCESS, 8'h80);
    wave_chk(6'h00, 7'h23);
  endtask

  task automatic wide_chk(input logic [7:0] cfg, input logic [6:0] sp, input logic exp);
    apb(1'b1, 2'd0, `ELC_IDX_RX_DEJITTER, cfg);
    rx_fifo_spread[0] <= sp;
    @(posedge pclk);
    @(posedge pclk);
    chk("track wide", {31'h0, exp}, {31'h0, rx_dejitter_track_wide[0]});
  endtask

  task automatic t_dejitter;
    for (int d = 0; d < 4; d++) begin
      apb(1'b1, 2'd3, `ELC_IDX_RX_DEJITTER, 8'h08 | 8'(d << 1) | 8'(d & 1));
      @(posedge pclk);
      chk("depth bits", (d == 0) ? 32'd128 : (d == 1) ? 32'd64 : 32'd32, {24'h0, rx_dejitter_bits[3]});
      chk("dj enable", 32'h1, {31'h0, rx_dejitter_enable[3]});
      chk("corner", 32'(d & 1), {31'h0, rx_dejitter_corner_select[3]});
    end
    apb(1'b1, 2'd3, `ELC_IDX_RX_DEJITTER, 8'h00);
    @(posedge pclk);
    chk("dj bypass", 32'h0, {31'h0, rx_dejitter_enable[3]});
    wide_chk(8'h18, 7'd4, 1'b1);
    wide_chk(8'h18, 7'd5, 1'b0);
    wide_chk(8'h18, 7'd124, 1'b1);
    wide_chk(8'h18, 7'd123, 1'b0);
    wide_chk(8'h1a, 7'd61, 1'b1);
    wide_chk(8'h1a, 7'd60, 1'b0);
    wide_chk(8'h1c, 7'd2, 1'b1);
    wide_chk(8'h1c, 7'd3, 1'b0);
    wide_chk(8'h08, 7'd2, 1'b0);
    rchk("spread live", 2'd0, `ELC_IDX_RX_SPREAD, 8'h02);
    apb(1'b1, 2'd0, `ELC_IDX_RX_DEJITTER, 8'h20);
    rx_fifo_spread[0] <= 7'h50;
    @(posedge pclk);
    rx_fifo_spread[0] <= 7'h10;
    rchk("spread peak", 2'd0, `ELC_IDX_RX_SPREAD, 8'h50);
  endtask

  task automatic t_rxpath;
    apb(1'b1, 2'd3, `ELC_IDX_RX_PATH, 8'h12);
    apb(1'b1, 2'd3, `ELC_IDX_RX_EQ_LOSS, 8'h47);
    @(posedge pclk);
    chk("power down", 32'h8, {28'h0, rx_power_down});
    chk("line code", 32'h8, {28'h0, rx_line_code_select});
    chk("equalizer", 32'h8, {28'h0, rx_equalizer_enable});
    chk("loss thr", 32'h07, {27'h0, rx_signal_loss_threshold[3]});
    rchk("rx path l3", 2'd3, `ELC_IDX_RX_PATH, 8'h12);
    rchk("rx path l0", 2'd0, `ELC_IDX_RX_PATH, 8'h00);
    rchk("eq loss l2", 2'd2, `ELC_IDX_RX_EQ_LOSS, 8'h15);
  endtask

  // ==========================================================
  // Main sequence and watchdog
  initial begin
    num_errors = 0;
    n_compared = 0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    pstrb = 4'hf;
    rx_fifo_spread = '0;
    tx_wave_addr = '0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset();
    t_shape();
    t_template();
    t_dejitter();
    t_rxpath();
    end_sim();
  end

  // Whole run needs well under 2000 cycles
  initial begin
    repeat (20000) @(posedge pclk);
    num_errors++;
    end_sim();
  end
endmodule // tb_e1_link_line_config_regs
`default_nettype wire
